// ==== hdl/drp_pkg.sv ====
// Shared constants and types for the drum record and playback control block.
package drp_pkg;

  // Clock and time figures.
  localparam int SYS_CLK_PERIOD_NS = 8;
  localparam int BIT_PERIOD_NS     = 10000;
  localparam int OSC_PERIOD_NS     = 10000;
  localparam int WRITE_PULSE_NS    = 2000;
  localparam int READ_DELAY_NS     = BIT_PERIOD_NS / 2;
  localparam int OSC_CYCLES        = OSC_PERIOD_NS / SYS_CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYCLES = (WRITE_PULSE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int READ_DELAY_CYCLES = READ_DELAY_NS / SYS_CLK_PERIOD_NS;
  localparam int DLY_W             = 12;

  // Drum geometry.
  localparam int WORD_BITS     = 48;
  localparam int BIT_W         = 6;
  localparam int SLOT_W        = 5;
  localparam int CHAN_W        = 6;
  localparam int NUM_CHANNELS  = 60;
  localparam logic [BIT_W-1:0]  BIT_LAST  = 6'h2F;
  localparam logic [BIT_W-1:0]  BIT_ONES  = 6'h3F;
  localparam logic [SLOT_W-1:0] SLOT_ONES = 5'h1F;
  localparam logic [SLOT_W-1:0] SEQ_LAST  = 5'h18;
  localparam logic [CHAN_W-1:0] CHAN_LAST = 6'h3B;

  // Timing track writer and input word FIFO.
  localparam int TRK_W = 11;
  localparam logic [TRK_W-1:0] TRK_OPEN  = 11'h140;
  localparam logic [TRK_W-1:0] TRK_CLOSE = 11'h600;
  localparam int FIFO_DEPTH = 4;

  typedef logic [WORD_BITS-1:0] drp_word_t;

  // Drum position and sequence carried together.
  typedef struct packed {
    logic [CHAN_W-1:0] channel;
    logic [SLOT_W-1:0] word_seq;
    logic [SLOT_W-1:0] word_slot;
    logic [BIT_W-1:0]  bit_pos;
  } drp_pos_t;

  typedef enum logic [1:0] {TRK_IDLE, TRK_ARMED, TRK_RUN} drp_trk_t;

endpackage

// ==== hdl/drp_fifo.sv ====
// Small word FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module drp_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer and count update; pushes stall while full.
  always_comb
  begin
    push        = in_valid && in_ready;
    pop         = out_ready && (count != '0);
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Registers the pointers, the count and the ready flag.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b0;
    end
    else
    begin
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      count    <= next_count;
      in_ready <= (next_count != FULL_CNT); // Registered so it stays low in reset.
    end
  end

  // Storage array holds no reset.
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
endmodule

// ==== hdl/drp_pulse_one_shot.sv ====
// Retriggerable one-shot that holds its output for a fixed cycle count.
`timescale 1ns/1ps
module drp_pulse_one_shot #(
  parameter int CYCLES = 250,
  parameter int CW     = 12
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic fire,
  output logic      pulse
);
  logic [CW-1:0] remain;
  logic [CW-1:0] next_remain;

  ////////////////////////////////////////////////////////////////////////////
  // Loads the width on a trigger and counts it away.
  always_comb
  begin
    if (fire)
      next_remain = CW'(CYCLES);
    else if (remain != '0)
      next_remain = remain - 1'b1;
    else
      next_remain = remain;
  end

  // Output is high while the count is running.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      remain <= '0;
      pulse  <= 1'b0;
    end
    else
    begin
      remain <= next_remain;
      pulse  <= (next_remain != '0);
    end
  end
endmodule

// ==== hdl/drp_drum_ctrl.sv ====
// Drum record and playback control: position counters, transfer gate and track writers.
//
// Contract
// - One channel selected through sixty relays
// - Matrix clock: drum timing or read logic
// - Shift output to write amp or arithmetic
// - Channel path to write or read amp
// - Record forces up count; playback follows flop
// - Relays switch in the sync gap
// - Sync before timing; both rewritable anytime
// - Eleven-stage counter limits track to 1216
// - Timing gate opens 320, closes 1536
// - Timing track from 100 Kc oscillator
// - Exclusive modes; record stores words continually
// - Write driver shifts at drum timing rate
// - RZ: one gives two-microsecond pulse
// - Write amplifier gets a gated clock
// - Playback samples on delayed timing pulses
// - Bit and word-slot counters track drum
// - Accept one 48-bit word per interval
// - Transfer only when sequence equals slot
// - After 25 words advance channel
// - Word pulse every 48 timing pulses
// - Sequence wraps 24 to 0, 0 to 24
// - Channel counter wraps after sixty
`timescale 1ns/1ps
module drp_drum_ctrl
  import drp_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  record_mode,
  input  wire logic                  drum_sync,
  input  wire logic                  drum_timing,
  input  wire logic                  drum_read_data,
  input  wire drp_pkg::drp_word_t    word_in,
  input  wire logic                  word_in_valid,
  output logic                       word_in_ready,
  input  wire logic                  play_req,
  input  wire logic                  up_down_ctl,
  input  wire logic                  run_enable,
  input  wire logic                  count_clear,
  input  wire logic                  sync_write_req,
  input  wire logic                  timing_write_req,
  output logic [NUM_CHANNELS-1:0]    relay_drive,
  output logic                       path_to_write_amp,
  output logic                       path_to_read_amp,
  output logic                       data_write_pulse,
  output logic                       timing_head_pulse,
  output logic                       sync_head_pulse,
  output drp_pkg::drp_word_t         arith_word,
  output logic                       arith_valid,
  output drp_pkg::drp_pos_t          drum_pos,
  output logic                       transfer_gate
);

  drp_word_t          fifo_data;
  logic               fifo_valid;
  logic               fifo_pop;
  drp_pos_t           pos;
  drp_pos_t           next_pos;
  logic               count_up;
  logic               word_pulse;
  logic               slot_match;
  logic               gate;
  logic               next_gate;
  logic [BIT_W-1:0]   bits_left;
  logic [BIT_W-1:0]   next_bits_left;
  drp_word_t          shreg;
  drp_word_t          next_shreg;
  logic               data_ff;
  logic               next_data_ff;
  logic               play_pend;
  logic               next_play_pend;
  logic               seq_step;
  logic               matrix_clk;
  logic [DLY_W-1:0]   dly;
  logic [DLY_W-1:0]   next_dly;
  logic               read_strobe;
  logic               rz_fire;
  drp_word_t          next_arith_word;
  logic               next_arith_valid;
  logic [CHAN_W-1:0]  relay_chan;
  logic [CHAN_W-1:0]  next_relay_chan;
  drp_trk_t           trk;
  drp_trk_t           next_trk;
  logic [TRK_W-1:0]   trk_cnt;
  logic [TRK_W-1:0]   next_trk_cnt;
  logic [DLY_W-1:0]   osc_div;
  logic [DLY_W-1:0]   next_osc_div;
  logic               osc_tick;
  logic               trk_fire;

  ////////////////////////////////////////////////////////////////////////////
  // Input words queue here until their slot comes round.
  drp_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_data   (word_in),
    .in_valid  (word_in_valid),
    .in_ready  (word_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Direction and position counters; bit and slot advance on drum timing, sequence and channel at transfer end.
  always_comb
  begin
    count_up   = record_mode ? 1'b1 : up_down_ctl;
    next_pos   = pos;
    word_pulse = 1'b0;
    if (drum_sync)
    begin
      next_pos.bit_pos   = BIT_ONES;
      next_pos.word_slot = SLOT_ONES;
    end
    else if (drum_timing)
    begin
      if (pos.bit_pos == BIT_LAST || pos.bit_pos == BIT_ONES)
      begin
        next_pos.bit_pos   = '0;
        word_pulse         = 1'b1;
        next_pos.word_slot = pos.word_slot + 1'b1;
      end
      else
        next_pos.bit_pos = pos.bit_pos + 1'b1;
    end
    // Sequence steps at the end of each transfer; channel steps only when the sequence wraps.
    if (count_clear)
    begin
      next_pos.word_seq = '0;
      next_pos.channel  = '0;
    end
    else if (seq_step)
    begin
      if (count_up)
      begin
        next_pos.word_seq = (pos.word_seq == SEQ_LAST) ? '0 : pos.word_seq + 1'b1;
        if (pos.word_seq == SEQ_LAST)
          next_pos.channel = (pos.channel == CHAN_LAST) ? '0 : pos.channel + 1'b1;
      end
      else
      begin
        next_pos.word_seq = (pos.word_seq == '0) ? SEQ_LAST : pos.word_seq - 1'b1;
        if (pos.word_seq == '0)
          next_pos.channel = (pos.channel == '0) ? CHAN_LAST : pos.channel - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer gate, shift register and data flip-flop.
  always_comb
  begin
    matrix_clk       = record_mode ? drum_timing : read_strobe;
    slot_match       = word_pulse && !drum_sync && (next_pos.word_slot == pos.word_seq);
    next_gate        = gate;
    next_bits_left   = bits_left;
    next_shreg       = shreg;
    next_data_ff     = data_ff;
    next_play_pend   = play_pend || (play_req && !record_mode);
    next_arith_word  = arith_word;
    next_arith_valid = 1'b0;
    fifo_pop         = 1'b0;
    seq_step         = 1'b0;
    if (!gate)
    begin
      if (record_mode && run_enable && fifo_valid && slot_match)
      begin
        fifo_pop       = 1'b1;
        next_gate      = 1'b1;
        next_data_ff   = fifo_data[0];
        next_shreg     = fifo_data >> 1;
        next_bits_left = BIT_W'(WORD_BITS - 1);
      end
      else if (!record_mode && run_enable && play_pend && slot_match)
      begin
        next_play_pend = play_req; // A new request set in this cycle wins.
        next_gate      = 1'b1;
        next_bits_left = BIT_W'(WORD_BITS);
      end
    end
    else if (matrix_clk)
    begin
      if (record_mode)
      begin
        // The last bit closes the gate so the next slot can open on its first pulse.
        next_data_ff   = shreg[0];
        next_shreg     = shreg >> 1;
        next_bits_left = bits_left - 1'b1;
        if (bits_left == 6'h01)
        begin
          next_gate = 1'b0;
          seq_step  = 1'b1;
        end
      end
      else
      begin
        next_data_ff   = drum_read_data;
        next_shreg     = {drum_read_data, shreg[WORD_BITS-1:1]};
        next_bits_left = bits_left - 1'b1;
        if (bits_left == 6'h01)
        begin
          next_gate        = 1'b0;
          next_arith_word  = {drum_read_data, shreg[WORD_BITS-1:1]};
          next_arith_valid = 1'b1;
          seq_step         = 1'b1;
        end
      end
    end
    if (!record_mode && (gate || next_gate) && drum_timing)
      next_dly = DLY_W'(READ_DELAY_CYCLES);
    else if (dly != '0)
      next_dly = dly - 1'b1;
    else
      next_dly = dly;
  end

  // Relay channel follows the counter only at sync, inside the gap.
  always_comb
  begin
    next_relay_chan = drum_sync ? pos.channel : relay_chan;
  end

  // Registers position, gate and data paths.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pos         <= '{channel: '0, word_seq: '0, word_slot: SLOT_ONES, bit_pos: BIT_ONES};
      gate        <= 1'b0;
      bits_left   <= '0;
      shreg       <= '0;
      data_ff     <= 1'b0;
      play_pend   <= 1'b0;
      dly         <= '0;
      read_strobe <= 1'b0;
      rz_fire     <= 1'b0;
      arith_word  <= '0;
      arith_valid <= 1'b0;
      relay_chan  <= '0;
    end
    else
    begin
      pos         <= next_pos;
      gate        <= next_gate;
      bits_left   <= next_bits_left;
      shreg       <= next_shreg;
      data_ff     <= next_data_ff;
      play_pend   <= next_play_pend;
      dly         <= next_dly;
      read_strobe <= (dly == DLY_W'(1));
      rz_fire     <= record_mode && (gate || next_gate) && drum_timing && next_data_ff;
      arith_word  <= next_arith_word;
      arith_valid <= next_arith_valid;
      relay_chan  <= next_relay_chan;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write driver: a one bit gates the timed pulse into the head.
  drp_pulse_one_shot #(
    .CYCLES (WRITE_PULSE_CYCLES),
    .CW     (DLY_W)
  ) u_data_pulse (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .fire    (rz_fire),
    .pulse   (data_write_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Timing track writer waits for the recorded sync, then gates the oscillator.
  always_comb
  begin
    osc_tick     = (osc_div == '0);
    next_osc_div = osc_tick ? DLY_W'(OSC_CYCLES - 1) : osc_div - 1'b1;
    next_trk     = trk;
    next_trk_cnt = trk_cnt;
    trk_fire     = 1'b0;
    case (trk)
      TRK_IDLE:
      begin
        if (timing_write_req)
          next_trk = TRK_ARMED;
      end
      TRK_ARMED:
      begin
        next_trk_cnt = '0;
        if (drum_sync)
          next_trk = TRK_RUN;
      end
      TRK_RUN:
      begin
        if (osc_tick)
        begin
          next_trk_cnt = trk_cnt + 1'b1;
          trk_fire     = (trk_cnt >= TRK_OPEN) && (trk_cnt < TRK_CLOSE);
          if (trk_cnt == TRK_CLOSE)
            next_trk = TRK_IDLE;
        end
      end
      default:
        next_trk = TRK_IDLE;
    endcase
  end

  // Registers the oscillator divider and track state.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_div <= '0;
      trk     <= TRK_IDLE;
      trk_cnt <= '0;
    end
    else
    begin
      osc_div <= next_osc_div;
      trk     <= next_trk;
      trk_cnt <= next_trk_cnt;
    end
  end

  // Timing head driver.
  drp_pulse_one_shot #(
    .CYCLES (WRITE_PULSE_CYCLES),
    .CW     (DLY_W)
  ) u_trk_pulse (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .fire    (trk_fire),
    .pulse   (timing_head_pulse)
  );

  // Sync head driver, usable at any time.
  drp_pulse_one_shot #(
    .CYCLES (WRITE_PULSE_CYCLES),
    .CW     (DLY_W)
  ) u_sync_pulse (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .fire    (sync_write_req),
    .pulse   (sync_head_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Relay tree drive and amplifier path selection, all registered.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHANNELS; gi++)
    begin : g_relay
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          relay_drive[gi] <= 1'b0;
        else
          relay_drive[gi] <= (next_relay_chan == CHAN_W'(gi));
      end
    end
  endgenerate

  // Path switches and status copies.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      path_to_write_amp <= 1'b0;
      path_to_read_amp  <= 1'b0;
      drum_pos          <= '0;
      transfer_gate     <= 1'b0;
    end
    else
    begin
      path_to_write_amp <= record_mode;
      path_to_read_amp  <= !record_mode;
      drum_pos          <= next_pos;
      transfer_gate     <= next_gate;
    end
  end

endmodule

// ==== test/drp_drum_model.sv ====
// Behavioural drum: one sync pulse, a gap, then a burst of timing pulses.
`timescale 1ns/1ps
module drp_drum_model #(
  parameter int PERIOD = 264,
  parameter int GAP    = 40
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [10:0] n_bits,
  output logic             drum_sync,
  output logic             drum_timing,
  output logic             drum_read_data,
  output logic             busy
);
  int cnt;
  int left;

  // Sync comes first, timing follows after the gap; sync and timing rest between bursts, read data toggles every cycle.
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      drum_sync <= 1'b0;
      drum_timing <= 1'b0;
      drum_read_data <= 1'b0;
      cnt <= 0;
      left <= 0;
    end
    else
    begin
      drum_sync <= 1'b0;
      drum_timing <= 1'b0;
      drum_read_data <= ~drum_read_data; // No track under the head: keep it moving.
      if (start && !busy)
      begin
        busy <= 1'b1;
        drum_sync <= 1'b1;
        cnt <= GAP + PERIOD;
        left <= n_bits;
      end
      else if (busy)
      begin
        if (cnt > 1)
          cnt <= cnt - 1;
        else
        begin
          drum_timing <= 1'b1;
          cnt <= PERIOD;
          left <= left - 1;
          busy <= (left > 1);
        end
      end
    end
  end
endmodule

// ==== test/drp_drum_ctrl_assertions.sv ====
// Port-level checks of the drum record and playback control.
`timescale 1ns/1ps
module drp_drum_ctrl_checker
  import drp_pkg::*;
(
  input wire logic                    sys_clk,
  input wire logic                    rst_n,
  input wire logic                    record_mode,
  input wire logic                    drum_sync,
  input wire logic                    drum_timing,
  input wire logic                    run_enable,
  input wire logic                    count_clear,
  input wire logic                    sync_write_req,
  input wire logic [NUM_CHANNELS-1:0] relay_drive,
  input wire logic                    path_to_write_amp,
  input wire logic                    path_to_read_amp,
  input wire logic                    data_write_pulse,
  input wire logic                    sync_head_pulse,
  input wire drp_pkg::drp_pos_t       drum_pos,
  input wire logic                    transfer_gate
);
  logic [8:0] sync_len;
  logic [8:0] next_sync_len;

  ////////////////////////////////////////////////////////////////////////////
  // Counts how long the current sync head pulse has stood.
  always_comb
  begin
    next_sync_len = sync_head_pulse ? sync_len + 9'h001 : 9'h000;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      sync_len <= 9'h000;
    else
      sync_len <= next_sync_len;
  end

  ////////////////////////////////////////////////////////////////////////////
  // All checks live in the one clock domain.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  relay_one_hot_a: assert property ($onehot0(relay_drive))
    else $error("relay drive selects more than one channel");
  relay_in_gap_a: assert property ($changed(relay_drive) && $past(rst_n, 2) |->
    $past(drum_sync))
    else $error("relay drive moved outside the sync gap");
  path_follows_mode_a: assert property ($past(rst_n) |->
    path_to_write_amp == $past(record_mode) && path_to_read_amp == !$past(record_mode))
    else $error("amplifier path does not follow the mode");
  modes_exclusive_a: assert property (!(path_to_write_amp && path_to_read_amp))
    else $error("both amplifier paths active");
  sync_write_a: assert property (sync_write_req |=> sync_head_pulse [*8])
    else $error("sync head pulse did not follow the request");
  sync_width_a: assert property ($fell(sync_head_pulse) |-> sync_len == WRITE_PULSE_CYCLES)
    else $error("sync head pulse has the wrong width");
  rz_after_timing_a: assert property ($rose(data_write_pulse) |-> $past(drum_timing, 2))
    else $error("write pulse not started by a timing pulse");
  gate_on_timing_a: assert property ($rose(transfer_gate) |->
    $past(drum_timing) && $past(run_enable) && !$past(drum_sync))
    else $error("transfer gate opened without its cause");
  count_range_a: assert property (drum_pos.word_seq <= SEQ_LAST &&
    drum_pos.channel <= CHAN_LAST)
    else $error("sequence or channel count out of range");
  clear_counts_a: assert property (count_clear |=>
    drum_pos.word_seq == 5'h00 && drum_pos.channel == 6'h00)
    else $error("clear did not zero the counts");

  gate_open_c: cover property ($rose(transfer_gate));
  sync_write_c: cover property ($fell(sync_head_pulse));
  write_pulse_c: cover property ($rose(data_write_pulse));
endmodule

bind drp_drum_ctrl drp_drum_ctrl_checker u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .record_mode(record_mode),
  .drum_sync(drum_sync), .drum_timing(drum_timing), .run_enable(run_enable),
  .count_clear(count_clear), .sync_write_req(sync_write_req),
  .relay_drive(relay_drive), .path_to_write_amp(path_to_write_amp),
  .path_to_read_amp(path_to_read_amp), .data_write_pulse(data_write_pulse),
  .sync_head_pulse(sync_head_pulse), .drum_pos(drum_pos), .transfer_gate(transfer_gate)
);

// ==== test/tb_top.sv ====
// Self-checking bench for the drum record and playback control.
`timescale 1ns/1ps
module tb_top;
  import drp_pkg::*;

  localparam int LIMIT = 70000;
  logic                    sys_clk, rst_n, record_mode, word_in_valid, word_in_ready;
  logic                    play_req, up_down_ctl, run_enable, count_clear;
  logic                    sync_write_req, timing_write_req, path_to_write_amp;
  logic                    path_to_read_amp, data_write_pulse, timing_head_pulse;
  logic                    sync_head_pulse, arith_valid, transfer_gate;
  logic                    drum_sync, drum_timing, drum_read_data, start, busy;
  logic [10:0]             n_bits;
  logic [NUM_CHANNELS-1:0] relay_drive;
  drp_word_t               word_in, arith_word, got;
  drp_pos_t                drum_pos;
  logic                    bits[$];
  logic                    gate_seen;
  int                      due, cycles, n_mismatch, tests_run;
  // Words to record; each one should appear in the write head pulses in the same order.
  drp_word_t rows[4] = '{48'h8000_0000_0001, 48'hFFFF_FFFF_FFFF,
                         48'h5A5A_C3C3_0F0F, 48'h7000_0000_000E};

  drp_drum_ctrl DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .record_mode(record_mode), .drum_sync(drum_sync),
    .drum_timing(drum_timing), .drum_read_data(drum_read_data), .word_in(word_in),
    .word_in_valid(word_in_valid), .word_in_ready(word_in_ready), .play_req(play_req),
    .up_down_ctl(up_down_ctl), .run_enable(run_enable), .count_clear(count_clear),
    .sync_write_req(sync_write_req), .timing_write_req(timing_write_req),
    .relay_drive(relay_drive), .path_to_write_amp(path_to_write_amp),
    .path_to_read_amp(path_to_read_amp), .data_write_pulse(data_write_pulse),
    .timing_head_pulse(timing_head_pulse), .sync_head_pulse(sync_head_pulse),
    .arith_word(arith_word), .arith_valid(arith_valid), .drum_pos(drum_pos),
    .transfer_gate(transfer_gate)
  );

  drp_drum_model drum (
    .sys_clk(sys_clk), .rst_n(rst_n), .start(start), .n_bits(n_bits),
    .drum_sync(drum_sync), .drum_timing(drum_timing), .drum_read_data(drum_read_data),
    .busy(busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compares one value and reports a mismatch.
  task automatic chk(input logic [63:0] act, input logic [63:0] exp);
    tests_run++;
    if (act !== exp)
      $display("[ERR] t=%0t got=%h exp=%h", $time, act, exp);
    if (act !== exp)
      n_mismatch++;
  endtask

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Offers one word and holds it until the FIFO takes it.
  task automatic push(input drp_word_t w);
    word_in = w;
    word_in_valid = 1'b1;
    while (word_in_ready !== 1'b1)
    begin
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    #1 word_in_valid = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  // Runs one drum burst of the given length and waits for it to end.
  task automatic burst(input logic [10:0] n);
    n_bits = n;
    start = 1'b1;
    @(posedge sys_clk);
    #1 start = 0;
    while (busy) @(posedge sys_clk);
    repeat (12) @(posedge sys_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 125 MHz.
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Samples the head drive ten cycles after every timing pulse.
  always @(posedge sys_clk)
  begin
    if (due == 1)
      bits.push_back(data_write_pulse);
    if (due > 0)
      due--;
    if (drum_timing)
      due = 10;
    if (transfer_gate)
      gate_seen = 1'b1;
    cycles++;
    if (cycles == LIMIT)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    {rst_n, word_in_valid, play_req, up_down_ctl, run_enable, count_clear} = '0;
    {sync_write_req, timing_write_req, start, gate_seen} = '0;
    {due, cycles, n_mismatch, tests_run} = '0;
    record_mode = 1'b1;
    word_in = '0;
    n_bits = 11'h000;
    repeat (20) @(posedge sys_clk);
    chk({relay_drive, transfer_gate, word_in_ready}, 64'h0);
    #1 rst_n = 1'b1;
    count_clear = 1'b1;
    @(posedge sys_clk);
    #1 count_clear = 1'b0;
    for (int i = 0; i < 4; i++)
      push(rows[i]);
    chk(word_in_ready, 1'b0);
    burst(11'h004);
    chk(gate_seen, 1'b0);
    chk(relay_drive, 60'h1);
    run_enable = 1'b1;
    bits.delete();
    burst(11'h0C8);
    chk(bits.size(), 200);
    chk({bits[192], bits[199]}, 2'b00);
    // Slot k holds the pulses 48k to 48k+47 after sync; bit 0 comes first.
    for (int k = 0; k < 4; k++)
    begin
      for (int b = 0; b < WORD_BITS; b++)
        got[b] = bits[k * WORD_BITS + b];
      chk(got, rows[k]);
    end
    chk({drum_pos.channel, drum_pos.word_seq}, 11'h004);
    chk(word_in_ready, 1'b1);
    count_clear = 1'b1;
    @(posedge sys_clk);
    #1 count_clear = 1'b0;
    chk(drum_pos.word_seq, 5'h00);
    sync_write_req = 1'b1;
    @(posedge sys_clk);
    #1 sync_write_req = 1'b0;
    chk(sync_head_pulse, 1'b1);
    repeat (260) @(posedge sys_clk);
    #1 chk(sync_head_pulse, 1'b0);
    record_mode = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk({path_to_write_amp, path_to_read_amp}, 2'b01);
    tally_and_finish();
  end
endmodule
